// *** design/ior_regs.vh ***
// register offsets, field masks and reset values of the i/o register window
`ifndef IOR_REGS_VH
`define IOR_REGS_VH

// window size and per-port count
`define IOR_WINDOW_BYTES 256
`define IOR_NUM_PORTS 7

// pin input registers
`define IOR_DIN_A 8'h00
`define IOR_DIN_B 8'h01
`define IOR_DIN_C 8'h10
`define IOR_DIN_D 8'h11
`define IOR_DIN_E 8'h30
`define IOR_DIN_F 8'h40
`define IOR_DIN_G 8'h41

// mode control registers, ports e, f, g only
`define IOR_MODE_E 8'h32
`define IOR_MODE_F 8'h42
`define IOR_MODE_G 8'h43

// output latch registers
`define IOR_DOUT_A 8'h04
`define IOR_DOUT_B 8'h05
`define IOR_DOUT_C 8'h14
`define IOR_DOUT_D 8'h15
`define IOR_DOUT_E 8'h34
`define IOR_DOUT_F 8'h44
`define IOR_DOUT_G 8'h45

// direction registers
`define IOR_DIR_A 8'h06
`define IOR_DIR_B 8'h07
`define IOR_DIR_C 8'h14
`define IOR_DIR_D 8'h15
`define IOR_DIR_E 8'h36
`define IOR_DIR_F 8'h46
`define IOR_DIR_G 8'h47

// driver select registers
`define IOR_DRV_A 8'h08
`define IOR_DRV_B 8'h09
`define IOR_DRV_C 8'h18
`define IOR_DRV_D 8'h19
`define IOR_DRV_E 8'h38
`define IOR_DRV_F 8'h48
`define IOR_DRV_G 8'h49

// input cell registers
`define IOR_ICELL_A 8'h0A
`define IOR_ICELL_B 8'h0B
`define IOR_ICELL_D 8'h1A

// driver enable status registers
`define IOR_ENST_A 8'h0C
`define IOR_ENST_B 8'h0D
`define IOR_ENST_C 8'h1C
`define IOR_ENST_D 8'h1B
`define IOR_ENST_F 8'h4C

// output cells and their write masks
`define IOR_OCELL_A 8'h20
`define IOR_OCELL_B 8'h21
`define IOR_OMASK_A 8'h22
`define IOR_OMASK_B 8'h23

// other registers
`define IOR_PWR0 8'hB0
`define IOR_PWR2 8'hB4
`define IOR_PROT1 8'hC0
`define IOR_PROT2 8'hC2
`define IOR_TEST_EN 8'hC7
`define IOR_PAGE 8'hE0
`define IOR_MEM_ID 8'hF1

// writable bit masks, unused bits read zero
`define IOR_PWR0_MASK 8'h3A
`define IOR_PWR2_MASK 8'h7D
`define IOR_TEST_EN_BIT 0

// reset values
`define IOR_RST_BYTE 8'h00

`endif

// *** design/ior_space.v ***
// i/o port register window: port latches, pin drivers, output cells, status registers
`include "ior_regs.vh"
`default_nettype none

module ior_space (
  // clock, clock enable and resets
  input wire mclk,
  input wire clk_en,
  input wire reset_n,
  input wire por_n,
  // host bus
  input wire [15:0] bus_addr,
  input wire [7:0] window_base,
  input wire bus_rd,
  input wire bus_wr,
  input wire [7:0] bus_wdata,
  output reg [7:0] bus_rdata_q,
  output reg bus_rvalid_q,
  // port pins, port a in bits 7:0 up to port g in bits 55:48
  input wire [55:0] pin_in,
  output reg [55:0] pin_out_q,
  output reg [55:0] pin_oe_n_q,
  output reg [55:0] pin_fast_q,
  // logic array side
  input wire [23:0] input_cell_bits,
  output wire [15:0] out_cells,
  // protection and identity status
  input wire [7:0] primary_protect,
  input wire [3:0] secondary_protect,
  input wire security_set,
  input wire [7:0] secondary_memory_identity,
  // control outputs
  output wire test_port_en,
  output wire [7:0] power_control_zero,
  output wire [7:0] power_control_two,
  output wire [7:0] address_page
);

  // {valid, offset} of a per-port register; valid low where the port lacks it
  function [8:0] off_din;
    input integer p;
    begin
      case (p)
        0: off_din = {1'b1, `IOR_DIN_A};
        1: off_din = {1'b1, `IOR_DIN_B};
        2: off_din = {1'b1, `IOR_DIN_C};
        3: off_din = {1'b1, `IOR_DIN_D};
        4: off_din = {1'b1, `IOR_DIN_E};
        5: off_din = {1'b1, `IOR_DIN_F};
        default: off_din = {1'b1, `IOR_DIN_G};
      endcase
    end
  endfunction

  function [8:0] off_dout;
    input integer p;
    begin
      case (p)
        0: off_dout = {1'b1, `IOR_DOUT_A};
        1: off_dout = {1'b1, `IOR_DOUT_B};
        2: off_dout = {1'b1, `IOR_DOUT_C};
        3: off_dout = {1'b1, `IOR_DOUT_D};
        4: off_dout = {1'b1, `IOR_DOUT_E};
        5: off_dout = {1'b1, `IOR_DOUT_F};
        default: off_dout = {1'b1, `IOR_DOUT_G};
      endcase
    end
  endfunction

  function [8:0] off_dir;
    input integer p;
    begin
      case (p)
        0: off_dir = {1'b1, `IOR_DIR_A};
        1: off_dir = {1'b1, `IOR_DIR_B};
        2: off_dir = {1'b1, `IOR_DIR_C};
        3: off_dir = {1'b1, `IOR_DIR_D};
        4: off_dir = {1'b1, `IOR_DIR_E};
        5: off_dir = {1'b1, `IOR_DIR_F};
        default: off_dir = {1'b1, `IOR_DIR_G};
      endcase
    end
  endfunction

  function [8:0] off_drv;
    input integer p;
    begin
      case (p)
        0: off_drv = {1'b1, `IOR_DRV_A};
        1: off_drv = {1'b1, `IOR_DRV_B};
        2: off_drv = {1'b1, `IOR_DRV_C};
        3: off_drv = {1'b1, `IOR_DRV_D};
        4: off_drv = {1'b1, `IOR_DRV_E};
        5: off_drv = {1'b1, `IOR_DRV_F};
        default: off_drv = {1'b1, `IOR_DRV_G};
      endcase
    end
  endfunction

  function [8:0] off_mode;
    input integer p;
    begin
      case (p)
        4: off_mode = {1'b1, `IOR_MODE_E};
        5: off_mode = {1'b1, `IOR_MODE_F};
        6: off_mode = {1'b1, `IOR_MODE_G};
        default: off_mode = {1'b0, `IOR_RST_BYTE};
      endcase
    end
  endfunction

  function [8:0] off_enst;
    input integer p;
    begin
      case (p)
        0: off_enst = {1'b1, `IOR_ENST_A};
        1: off_enst = {1'b1, `IOR_ENST_B};
        2: off_enst = {1'b1, `IOR_ENST_C};
        3: off_enst = {1'b1, `IOR_ENST_D};
        5: off_enst = {1'b1, `IOR_ENST_F};
        default: off_enst = {1'b0, `IOR_RST_BYTE};
      endcase
    end
  endfunction

  // ports whose drive bit means open drain; the others use it for slew rate
  function is_od_port;
    input integer p;
    begin
      is_od_port = (p != 2) && (p != 5);
    end
  endfunction

  // per-port configuration
  reg [7:0] dout_q [0:6];
  reg [7:0] dir_q [0:6];
  reg [7:0] drv_q [0:6];
  reg [7:0] mode_q [0:6];
  // output cells, masks and other registers
  reg [7:0] ocell_a_q;
  reg [7:0] ocell_b_q;
  reg [7:0] omask_a_q;
  reg [7:0] omask_b_q;
  reg [7:0] pwr0_q;
  reg [7:0] pwr2_q;
  reg test_en_q;
  reg [7:0] page_q;
  reg [15:0] addr_q;
  // pin synchronisers and settled level
  reg [55:0] pin_s1_q;
  reg [55:0] pin_s2_q;
  reg [55:0] pin_s3_q;
  reg [55:0] pin_lvl_q;
  // next-state values
  reg [7:0] rdata_d;
  reg [55:0] pin_out_d;
  reg [55:0] pin_oe_n_d;
  reg [55:0] pin_fast_d;
  integer p;
  integer b;
  integer i;
  // each process owns its own loop index so no variable has two drivers
  integer pw;
  integer pr;
  reg en_b;
  reg val_b;
  reg od_b;

  wire hit = (bus_addr[15:8] == window_base);
  wire [7:0] ofs = bus_addr[7:0];
  wire wr_hit = bus_wr & hit;
  wire rd_hit = bus_rd & hit;

  assign out_cells = {ocell_b_q, ocell_a_q};
  assign test_port_en = test_en_q;
  assign power_control_zero = pwr0_q;
  assign power_control_two = pwr2_q;
  assign address_page = page_q;

  // three-stage pin sync; a bit settles once stages two and three agree
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_q <= 56'h00000000000000;
      pin_s2_q <= 56'h00000000000000;
      pin_s3_q <= 56'h00000000000000;
      pin_lvl_q <= 56'h00000000000000;
    end else if (clk_en) begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_lvl_q <= (pin_s2_q & pin_s3_q) | (pin_lvl_q & (pin_s2_q ^ pin_s3_q));
    end
  end

  // power control zero sits on the power-up reset so reset pulses keep it
  always @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      pwr0_q <= `IOR_RST_BYTE;
    end else if (clk_en && wr_hit && ofs == `IOR_PWR0) begin
      pwr0_q <= bus_wdata & `IOR_PWR0_MASK;
    end
  end

  // host writes; the shared c/d latch and direction offsets load both registers
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (pw = 0; pw < `IOR_NUM_PORTS; pw = pw + 1) begin
        dout_q[pw] <= `IOR_RST_BYTE;
        dir_q[pw] <= `IOR_RST_BYTE;
        drv_q[pw] <= `IOR_RST_BYTE;
        mode_q[pw] <= `IOR_RST_BYTE;
      end
      ocell_a_q <= `IOR_RST_BYTE;
      ocell_b_q <= `IOR_RST_BYTE;
      omask_a_q <= `IOR_RST_BYTE;
      omask_b_q <= `IOR_RST_BYTE;
      pwr2_q <= `IOR_RST_BYTE;
      test_en_q <= 1'b0;
      page_q <= `IOR_RST_BYTE;
      addr_q <= 16'h0000;
    end else if (clk_en) begin
      // address is latched on every bus strobe for address-out pins
      if (bus_rd || bus_wr) begin
        addr_q <= bus_addr;
      end
      for (pw = 0; pw < `IOR_NUM_PORTS; pw = pw + 1) begin
        if (wr_hit && {1'b1, ofs} == off_dout(pw)) begin
          dout_q[pw] <= bus_wdata;
        end
        if (wr_hit && {1'b1, ofs} == off_dir(pw)) begin
          dir_q[pw] <= bus_wdata;
        end
        if (wr_hit && {1'b1, ofs} == off_drv(pw)) begin
          drv_q[pw] <= bus_wdata;
        end
        if (wr_hit && {1'b1, ofs} == off_mode(pw)) begin
          mode_q[pw] <= bus_wdata;
        end
      end
      if (wr_hit && ofs == `IOR_OCELL_A) begin
        ocell_a_q <= (bus_wdata & ~omask_a_q) | (ocell_a_q & omask_a_q);
      end
      if (wr_hit && ofs == `IOR_OCELL_B) begin
        ocell_b_q <= (bus_wdata & ~omask_b_q) | (ocell_b_q & omask_b_q);
      end
      if (wr_hit && ofs == `IOR_OMASK_A) begin
        omask_a_q <= bus_wdata;
      end
      if (wr_hit && ofs == `IOR_OMASK_B) begin
        omask_b_q <= bus_wdata;
      end
      if (wr_hit && ofs == `IOR_PWR2) begin
        pwr2_q <= bus_wdata & `IOR_PWR2_MASK;
      end
      if (wr_hit && ofs == `IOR_TEST_EN) begin
        test_en_q <= bus_wdata[`IOR_TEST_EN_BIT];
      end
      if (wr_hit && ofs == `IOR_PAGE) begin
        page_q <= bus_wdata;
      end
    end
  end

  // pin drivers; open drain only pulls low, so a high bit releases the pin
  always @* begin
    pin_out_d = 56'h00000000000000;
    pin_oe_n_d = {56{1'b1}};
    pin_fast_d = 56'h00000000000000;
    en_b = 1'b0;
    val_b = 1'b0;
    od_b = 1'b0;
    i = 0;
    for (p = 0; p < `IOR_NUM_PORTS; p = p + 1) begin
      for (b = 0; b < 8; b = b + 1) begin
        i = 8 * p + b;
        en_b = dir_q[p][b] | mode_q[p][b];
        // address-out mode: e and f carry the low address byte, g the high
        val_b = mode_q[p][b] ? addr_q[(p == 6) ? 8 + b : b] : dout_q[p][b];
        od_b = drv_q[p][b] & is_od_port(p);
        pin_out_d[i] = val_b & ~od_b;
        pin_oe_n_d[i] = ~(en_b & (~od_b | ~val_b));
        pin_fast_d[i] = drv_q[p][b] & ~is_od_port(p);
      end
    end
  end

  // pin outputs registered so they never glitch on a decode change
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out_q <= 56'h00000000000000;
      pin_oe_n_q <= {56{1'b1}};
      pin_fast_q <= 56'h00000000000000;
    end else if (clk_en) begin
      pin_out_q <= pin_out_d;
      pin_oe_n_q <= pin_oe_n_d;
      pin_fast_q <= pin_fast_d;
    end
  end

  // read mux; on the shared c/d offsets the output latch wins
  always @* begin
    rdata_d = `IOR_RST_BYTE;
    for (pr = `IOR_NUM_PORTS - 1; pr >= 0; pr = pr - 1) begin
      if ({1'b1, ofs} == off_din(pr)) begin
        rdata_d = pin_lvl_q[8 * pr +: 8];
      end else if ({1'b1, ofs} == off_dout(pr)) begin
        rdata_d = dout_q[pr];
      end else if ({1'b1, ofs} == off_dir(pr)) begin
        rdata_d = dir_q[pr];
      end else if ({1'b1, ofs} == off_drv(pr)) begin
        rdata_d = drv_q[pr];
      end else if ({1'b1, ofs} == off_mode(pr)) begin
        rdata_d = mode_q[pr];
      end else if ({1'b1, ofs} == off_enst(pr)) begin
        rdata_d = ~pin_oe_n_q[8 * pr +: 8];
      end
    end
    if (ofs == `IOR_ICELL_A) begin
      rdata_d = input_cell_bits[7:0];
    end else if (ofs == `IOR_ICELL_B) begin
      rdata_d = input_cell_bits[15:8];
    end else if (ofs == `IOR_ICELL_D) begin
      rdata_d = input_cell_bits[23:16];
    end else if (ofs == `IOR_OCELL_A) begin
      rdata_d = ocell_a_q;
    end else if (ofs == `IOR_OCELL_B) begin
      rdata_d = ocell_b_q;
    end else if (ofs == `IOR_OMASK_A) begin
      rdata_d = omask_a_q;
    end else if (ofs == `IOR_OMASK_B) begin
      rdata_d = omask_b_q;
    end else if (ofs == `IOR_PWR0) begin
      rdata_d = pwr0_q;
    end else if (ofs == `IOR_PWR2) begin
      rdata_d = pwr2_q;
    end else if (ofs == `IOR_PROT1) begin
      rdata_d = primary_protect;
    end else if (ofs == `IOR_PROT2) begin
      rdata_d = {security_set, 3'h0, secondary_protect};
    end else if (ofs == `IOR_TEST_EN) begin
      rdata_d = {7'h00, test_en_q};
    end else if (ofs == `IOR_PAGE) begin
      rdata_d = page_q;
    end else if (ofs == `IOR_MEM_ID) begin
      rdata_d = secondary_memory_identity;
    end
  end

  // read answer one cycle after the strobe, data held until the next read
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata_q <= `IOR_RST_BYTE;
      bus_rvalid_q <= 1'b0;
    end else if (clk_en) begin
      bus_rvalid_q <= rd_hit;
      if (rd_hit) begin
        bus_rdata_q <= rdata_d;
      end
    end
  end

endmodule // ior_space

`default_nettype wire

// *** tb/ior_host_model.sv ***
// host bus model: byte reads and writes on the register window
`default_nettype none
module ior_host_model (
  // clock
  input wire logic mclk,
  // host bus
  output logic [15:0] bus_addr,
  output logic bus_rd,
  output logic bus_wr,
  output logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata_q,
  input wire logic bus_rvalid_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    bus_addr = 16'h0000;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_wdata = 8'h00;
  end
  // one write strobe; data is inverted after release so a stale byte never looks valid
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge mclk);
    bus_wr = 1'b0;
    bus_wdata = ~d;
  endtask
  // one read strobe; the answer is taken one edge after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    @(negedge mclk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge mclk);
    bus_rd = 1'b0;
    d = bus_rdata_q;
    ok = bus_rvalid_q;
  endtask
endmodule // ior_host_model
`default_nettype wire

// *** tb/ior_space_assertions.sv ***
// bus and output checks for the i/o register window
`default_nettype none
module ior_space_checker (
  // clock and resets
  input wire logic mclk,
  input wire logic clk_en,
  input wire logic reset_n,
  input wire logic por_n,
  // host bus
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] window_base,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata_q,
  input wire logic bus_rvalid_q,
  // outputs
  input wire logic [55:0] pin_fast_q,
  input wire logic [15:0] out_cells,
  input wire logic test_port_en,
  input wire logic [7:0] power_control_zero,
  input wire logic [7:0] address_page
);
  timeunit 1ns;
  timeprecision 1ns;
  // request taken inside the window; oc_wr marks a write to either output cell byte
  wire logic inwin = clk_en && (bus_addr[15:8] == window_base);
  wire logic oc_wr = inwin && bus_wr && (bus_addr[7:1] == 7'h10);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_rd;
    inwin && bus_rd;
  endsequence
  sequence s_wr(off);
    inwin && bus_wr && (bus_addr[7:0] == off);
  endsequence
  a_read_answered: assert property (s_rd |=> bus_rvalid_q)
    else $error("read in window not answered");
  a_no_stray_valid: assert property (clk_en && !(inwin && bus_rd) |=> !bus_rvalid_q)
    else $error("valid without read");
  a_rdata_holds: assert property ($changed(bus_rdata_q) |-> bus_rvalid_q)
    else $error("read data moved without valid");
  a_page_loads: assert property (s_wr(8'hE0) |=> address_page == $past(bus_wdata))
    else $error("page not loaded");
  a_test_port_bit: assert property (s_wr(8'hC7) |=> test_port_en == $past(bus_wdata[0]))
    else $error("test port enable wrong");
  a_power_mask: assert property (s_wr(8'hB0) |=>
    power_control_zero == ($past(bus_wdata) & 8'h3A)) else $error("power control zero wrong");
  a_power_keeps: assert property (disable iff (!por_n)
    !reset_n && !bus_wr |=> $stable(power_control_zero)) else $error("power zero lost in reset");
  a_cells_cause: assert property ($changed(out_cells) |-> $past(oc_wr))
    else $error("output cells moved without write");
  a_slew_cf_only: assert property (pin_fast_q[15:0] == 16'h0000 &&
    pin_fast_q[39:24] == 16'h0000 && pin_fast_q[55:48] == 8'h00) else $error("slew on wrong port");
endmodule // ior_space_checker
bind ior_space ior_space_checker u_ior_space_checker (.mclk, .clk_en, .reset_n, .por_n,
  .bus_addr, .window_base, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata_q, .bus_rvalid_q,
  .pin_fast_q, .out_cells, .test_port_en, .power_control_zero, .address_page);
`default_nettype wire

// *** tb/ior_space_test.sv ***
// self-checking bench for the i/o register window
`include "ior_regs.vh"
`default_nettype none
module ior_space_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, clk_en, reset_n, por_n, bus_rd, bus_wr, security_set, test_port_en, bus_rvalid_q;
  logic [7:0] window_base, bus_wdata, bus_rdata_q, primary_protect, secondary_memory_identity;
  logic [7:0] power_control_zero, power_control_two, address_page, rv;
  logic [15:0] bus_addr, out_cells;
  logic [3:0] secondary_protect;
  logic [23:0] input_cell_bits;
  logic [55:0] pin_in, pin_out_q, pin_oe_n_q, pin_fast_q, ext;
  logic ok;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  // pin level: driven bits follow the block, released bits follow the outside world
  assign pin_in = (pin_out_q & ~pin_oe_n_q) | (ext & pin_oe_n_q);
  ior_space u_ior_space (.mclk, .clk_en, .reset_n, .por_n, .bus_addr, .window_base, .bus_rd,
    .bus_wr, .bus_wdata, .bus_rdata_q, .bus_rvalid_q, .pin_in, .pin_out_q, .pin_oe_n_q,
    .pin_fast_q, .input_cell_bits, .out_cells, .primary_protect, .secondary_protect,
    .security_set, .secondary_memory_identity, .test_port_en, .power_control_zero,
    .power_control_two, .address_page);
  ior_host_model u_ior_host_model (.mclk, .bus_addr, .bus_rd, .bus_wr, .bus_wdata,
    .bus_rdata_q, .bus_rvalid_q);
  // clock, 100 ns period
  always #50 mclk = ~mclk;
  // hang guard, far above the roughly 134 cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      test_done();
    end
  end
  task automatic test_done();
    if (failures == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // read one window offset, expect an answer and the byte
  task automatic rdchk(input logic [7:0] off, input logic [7:0] exp);
    u_ior_host_model.rd({window_base, off}, rv, ok);
    chk({7'h00, ok}, 8'h01);
    chk(rv, exp);
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    u_ior_host_model.wr({window_base, off}, d);
  endtask
  // pin outputs follow a config change two edges later
  task automatic settle();
    repeat (2) @(negedge mclk);
  endtask
  task automatic t_reset();
    chk({7'h00, &pin_oe_n_q}, 8'h01);
    rdchk(`IOR_DIR_A, 8'h00);
    rdchk(`IOR_DRV_A, 8'h00);
    rdchk(`IOR_ENST_C, 8'h00);
    rdchk(`IOR_MODE_E, 8'h00);
    rdchk(`IOR_PWR0, 8'h00);
  endtask
  // offset, written byte, byte read back
  task automatic t_regs();
    logic [7:0] t [12][3] = '{'{`IOR_PAGE, 8'h5A, 8'h5A}, '{`IOR_PWR0, 8'hFF, 8'h3A},
      '{`IOR_PWR2, 8'hFF, 8'h7D}, '{`IOR_TEST_EN, 8'hFF, 8'h01}, '{`IOR_DRV_C, 8'hA5, 8'hA5},
      '{`IOR_MODE_G, 8'h3C, 8'h3C}, '{8'h02, 8'hFF, 8'h00}, '{`IOR_DIN_B, 8'hFF, 8'h00},
      '{`IOR_PROT1, 8'hFF, 8'h6B}, '{`IOR_PROT2, 8'hFF, 8'h89}, '{`IOR_MEM_ID, 8'hFF, 8'h2E},
      '{`IOR_ENST_F, 8'hFF, 8'h00}};
    for (int i = 0; i < 12; i++) begin
      wr(t[i][0], t[i][1]);
      rdchk(t[i][0], t[i][2]);
    end
    chk({7'h00, test_port_en}, 8'h01);
    chk(power_control_zero, 8'h3A);
    chk(power_control_two, 8'h7D);
    chk(address_page, 8'h5A);
    chk(pin_fast_q[23:16], 8'hA5);
    wr(`IOR_TEST_EN, 8'hFE);
    chk({7'h00, test_port_en}, 8'h00);
  endtask
  task automatic t_window();
    u_ior_host_model.rd({8'h7B, `IOR_PAGE}, rv, ok);
    chk({7'h00, ok}, 8'h00);
    u_ior_host_model.wr({8'h7B, `IOR_PAGE}, 8'h11);
    @(negedge mclk) window_base = 8'h12;
    rdchk(`IOR_PAGE, 8'h5A);
    window_base = 8'h7A;
  endtask
  task automatic t_pins();
    @(negedge mclk) ext[7:0] = 8'hC3;
    repeat (4) @(negedge mclk);
    rdchk(`IOR_DIN_A, 8'hC3);
    wr(`IOR_DOUT_A, 8'h96);
    wr(`IOR_DIR_A, 8'hF0);
    settle();
    chk(pin_oe_n_q[7:0], 8'h0F);
    chk({4'h0, pin_out_q[7:4]}, 8'h09);
    rdchk(`IOR_ENST_A, 8'hF0);
    wr(`IOR_DRV_A, 8'hF0);
    settle();
    chk(pin_oe_n_q[7:0], 8'h9F);
    chk({4'h0, pin_out_q[7:4]}, 8'h00);
    wr(`IOR_DOUT_C, 8'h0F);
    settle();
    chk(pin_oe_n_q[23:16], 8'hF0);
    chk({4'h0, pin_out_q[19:16]}, 8'h0F);
  endtask
  // latched address bit 0 shows on port e pin 0
  task automatic t_mode();
    wr(`IOR_MODE_E, 8'h01);
    u_ior_host_model.rd({window_base, 8'h41}, rv, ok);
    settle();
    chk({6'h00, pin_oe_n_q[32], pin_out_q[32]}, 8'h01);
    u_ior_host_model.rd({window_base, 8'h40}, rv, ok);
    settle();
    chk({6'h00, pin_oe_n_q[32], pin_out_q[32]}, 8'h00);
    // port g mode bits 5:2 carry address bits 13:10 of the last strobe
    chk(pin_out_q[55:48], 8'h38);
  endtask
  task automatic t_cells();
    wr(`IOR_OCELL_A, 8'hA5);
    chk(out_cells[7:0], 8'hA5);
    rdchk(`IOR_OCELL_A, 8'hA5);
    wr(`IOR_OMASK_A, 8'hF0);
    wr(`IOR_OCELL_A, 8'h5A);
    chk(out_cells[7:0], 8'hAA);
    wr(`IOR_OCELL_B, 8'h3C);
    rdchk(`IOR_OCELL_B, 8'h3C);
    rdchk(`IOR_OMASK_A, 8'hF0);
    rdchk(`IOR_ICELL_A, 8'h81);
    rdchk(`IOR_ICELL_B, 8'h5A);
    rdchk(`IOR_ICELL_D, 8'h3C);
  endtask
  // a write while the clock enable is low must not land
  task automatic t_freeze();
    @(negedge mclk) clk_en = 1'b0;
    wr(`IOR_PAGE, 8'h33);
    @(negedge mclk) clk_en = 1'b1;
    rdchk(`IOR_PAGE, 8'h5A);
  endtask
  // a plain reset pulse must spare power control zero
  task automatic t_pwr_keep();
    @(negedge mclk) reset_n = 1'b0;
    @(negedge mclk) reset_n = 1'b1;
    chk({7'h00, &pin_oe_n_q}, 8'h01);
    rdchk(`IOR_PWR0, 8'h3A);
    rdchk(`IOR_PAGE, 8'h00);
  endtask
  initial begin
    mclk = 1'b0;
    clk_en = 1'b1;
    reset_n = 1'b0;
    por_n = 1'b0;
    window_base = 8'h7A;
    ext = 56'h0;
    input_cell_bits = 24'h3C5A81;
    primary_protect = 8'h6B;
    secondary_protect = 4'h9;
    security_set = 1'b1;
    secondary_memory_identity = 8'h2E;
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    por_n = 1'b1;
    t_reset();
    t_regs();
    t_window();
    t_pins();
    t_mode();
    t_cells();
    t_freeze();
    t_pwr_keep();
    test_done();
  end
endmodule // ior_space_test
`default_nettype wire
